// ==== design/rcsd_core.sv ====
`timescale 1ns/100ps
`include "rcsd_defines.svh"
// Functional notes
// [R1] Config registers 8 bits, reset to defaults
// [R2] Host rewrites non-default settings after reset
// [R3] Thirteen strobe addresses trigger actions, store nothing
// [R4] Forty-seven plain writable configuration registers
// [R5] Twelve read-only status registers ignore writes
// [R6] One FIFO address: write pushes, read pops
// [R7] Status byte shifts out during header, writes
// [R8] Burst bit meaning depends on base address
// [R9] Synth-on strobe, calibrate first, CCA wait
// [R10] Calibrate strobe then synth off, from idle
// [R11] Receive strobe, calibrate first from idle
// [R12] Transmit strobe, CCA gates from receive
// [R13] Idle strobe ends receive, transmit, polling
// [R14] Polling strobe only when RC oscillator powered
// [R15] Power down when chip select rises
// [R16] Receive flush only in idle or overflow
// [R17] Transmit flush only in idle or underflow
// [R18] Timer reload strobe loads Event1 value
// [R19] Oscillator-off strobe stops crystal oscillator
// [R20] No-op returns status; reset strobe resets chip
// [R21] Strobe acts on its complete header byte
module rcsd_core
	import rcsd_pkg::*;
#(
	parameter int unsigned CAL_CYCLES = `RCSD_CAL_TIME_US * `RCSD_CLK_MHZ
)
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_chip_select_n,
	input wire logic i_mosi,
	input wire logic i_channel_clear,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_octet,
	input wire logic i_tx_take,
	output logic o_so,
	output logic o_so_oe,
	output logic [7:0] o_tx_octet,
	output logic o_tx_strobe,
	output logic [7:0] o_radio_state,
	output logic o_power_down,
	output logic o_xosc_off
);
	// Whole core state
	typedef struct packed {
		logic [`RCSD_NUM_CFG-1:0][7:0] cfg; // Configuration registers
		rcsd_radio_e radio; // Radio control state
		rcsd_radio_e cal_target; // State after calibration
		logic [`RCSD_CAL_CNT_W-1:0] cal_cnt; // Calibration timer
		logic [15:0] wor_cnt; // Wake timer
		logic pwd_pend; // Power down waits for chip select
		logic [5:0] addr; // Current access address
		logic rw; // Current access is a read
		logic burst; // Current access is a burst
		logic hdr_ok; // Header seen in this frame
		logic refill; // Reload read byte after a pop
		rcsd_ret_s ret; // Bytes for the serial link
		logic [7:0] tx_out; // Byte handed to the modem
		logic tx_stb; // Handed byte is new
		logic [2:0] tog_sync; // Request toggle synchroniser
		logic [2:0] cs_sync; // Chip select synchroniser
		logic oe; // Serial output driven
		logic pd_out; // Power down indication
		logic xoff_out; // Oscillator off indication
	} rcsd_core_s;

	localparam logic [`RCSD_CAL_CNT_W-1:0] CAL_LAST = `RCSD_CAL_CNT_W'(CAL_CYCLES - 1);

	rcsd_core_s s_reg; // Registered state
	rcsd_core_s s_next; // Next state
	rcsd_ev_s ev_word; // Byte from the link domain
	logic ev_tog; // Request toggle from the link domain
	logic ev; // New byte this cycle
	logic strobe; // Header carries a strobe
	logic [5:0] hdr_addr; // Address field of the arriving byte
	logic [5:0] ra; // Address to be read next
	logic [7:0] rd_val; // Value at that address
	logic autocal; // Calibrate when leaving idle
	logic cca; // Clear channel assessment enabled
	logic rc_off; // RC oscillator powered down
	logic [15:0] evt1; // Wake timer reload value
	logic cs_fall; // Chip select went low
	logic data_wr; // Data byte written
	logic tx_push, tx_pop, tx_flush;
	logic rx_push, rx_pop, rx_flush;
	logic [7:0] tx_head, rx_head;
	logic [6:0] tx_count, rx_count;

	// Strobe addresses: 0x30..0x3D without 0x37, unless the header is a burst read
	function automatic logic is_strobe(input logic [5:0] a, input logic rw, input logic bu);
		return (a >= `RCSD_CMD_CHIP_RESET) && (a <= `RCSD_CMD_NO_OP) && (a != `RCSD_CMD_GAP)
			&& !(rw && bu);
	endfunction : is_strobe

	// Three-bit state field of the status byte
	function automatic logic [2:0] state_code(input rcsd_radio_e r);
		unique case (r)
			rad_idle, rad_wor, rad_xoff, rad_pwd: return 3'h0;
			rad_rx: return 3'h1;
			rad_tx: return 3'h2;
			rad_fs_on: return 3'h3;
			rad_cal: return 3'h4;
			rad_rxovf: return 3'h6;
			rad_txunf: return 3'h7;
		endcase
	endfunction : state_code

	// Serial link on the host's clock
	rcsd_spi_link u_link (
		.i_rst(i_rst),
		.i_sclk(i_sclk),
		.i_chip_select_n(i_chip_select_n),
		.i_mosi(i_mosi),
		.i_ret(s_reg.ret),
		.o_ev(ev_word),
		.o_req_tog(ev_tog),
		.o_so(o_so)
	);

	// Transmit FIFO, filled by the host, drained by the modem
	rcsd_fifo u_tx_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_push(tx_push),
		.i_pop(tx_pop),
		.i_flush(tx_flush),
		.i_data(ev_word.octet),
		.o_head(tx_head),
		.o_count(tx_count)
	);

	// Receive FIFO, filled by the modem, drained by the host
	rcsd_fifo u_rx_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_push(rx_push),
		.i_pop(rx_pop),
		.i_flush(rx_flush),
		.i_data(i_rx_octet),
		.o_head(rx_head),
		.o_count(rx_count)
	);

	// Configuration fields steering the radio control
	assign autocal = s_reg.cfg[`RCSD_RADIO_SM_CONFIG0_IDX][`RCSD_AUTOCAL_MSB:`RCSD_AUTOCAL_LSB]
		== `RCSD_AUTOCAL_FROM_IDLE;
	assign cca = s_reg.cfg[`RCSD_RADIO_SM_CONFIG1_IDX][`RCSD_CCA_MSB:`RCSD_CCA_LSB] != 2'h0;
	assign rc_off = s_reg.cfg[`RCSD_WAKE_POLL_CONTROL_IDX][`RCSD_RC_OSC_POWERDOWN_BIT];
	assign evt1 = 16'(s_reg.cfg[`RCSD_WAKE_POLL_CONTROL_IDX][`RCSD_EVT1_MSB:`RCSD_EVT1_LSB]);

	// Byte decode
	always_comb
	begin
		ev = s_reg.tog_sync[2] ^ s_reg.tog_sync[1];
		cs_fall = s_reg.cs_sync[2] && !s_reg.cs_sync[1];
		hdr_addr = ev_word.octet[5:0];
		strobe = ev && ev_word.is_hdr
			&& is_strobe(hdr_addr, ev_word.octet[7], ev_word.octet[6]); // R3 R8 R21
		data_wr = ev && !ev_word.is_hdr && s_reg.hdr_ok && !s_reg.rw;
		// Config bursts step the address; FIFO and status keep it
		if (ev && ev_word.is_hdr)
			ra = hdr_addr;
		else if (s_reg.burst && s_reg.addr <= `RCSD_CFG_LAST)
			ra = s_reg.addr + 6'h01; // R8
		else
			ra = s_reg.addr;
	end

	// Read value of an address
	always_comb
	begin
		rd_val = 8'h00;
		if (ra <= `RCSD_CFG_LAST)
			rd_val = s_reg.cfg[ra];
		else if (ra == `RCSD_FIFO_ADDR)
			rd_val = rx_head;
		else if (ra == 6'h30)
			rd_val = `RCSD_PART_ID;
		else if (ra == 6'h31)
			rd_val = `RCSD_VERSION_ID;
		else if (ra == 6'h35)
			rd_val = 8'(s_reg.radio); // R5
		else if (ra == 6'h36)
			rd_val = s_reg.wor_cnt[15:8];
		else if (ra == 6'h37)
			rd_val = s_reg.wor_cnt[7:0];
		else if (ra == 6'h38)
			rd_val = {7'h00, i_channel_clear};
		else if (ra == 6'h3A)
			rd_val = {s_reg.radio == rad_txunf, tx_count};
		else if (ra == `RCSD_STAT_LAST)
			rd_val = {s_reg.radio == rad_rxovf, rx_count};
	end

	// Next state of the core
	always_comb
	begin
		s_next = s_reg;
		s_next.tog_sync = {s_reg.tog_sync[1:0], ev_tog};
		s_next.cs_sync = {s_reg.cs_sync[1:0], i_chip_select_n};
		s_next.oe = !s_reg.cs_sync[1];
		s_next.tx_stb = 1'b0;
		s_next.refill = 1'b0;
		tx_push = 1'b0;
		rx_pop = 1'b0;
		tx_flush = 1'b0;
		rx_flush = 1'b0;
		// Modem side of the FIFOs
		rx_push = i_rx_valid && s_reg.radio == rad_rx && rx_count != `RCSD_FIFO_DEPTH;
		tx_pop = i_tx_take && s_reg.radio == rad_tx && tx_count != 7'h00;
		if (tx_pop)
		begin
			s_next.tx_out = tx_head;
			s_next.tx_stb = 1'b1;
		end
		// Header or data byte from the host
		if (ev && ev_word.is_hdr)
		begin
			s_next.addr = hdr_addr;
			s_next.rw = ev_word.octet[7];
			s_next.burst = ev_word.octet[6];
			s_next.hdr_ok = 1'b1;
		end
		else if (ev && s_reg.hdr_ok)
		begin
			if (data_wr && s_reg.addr <= `RCSD_CFG_LAST)
				s_next.cfg[s_reg.addr] = ev_word.octet; // R4
			if (data_wr && s_reg.addr == `RCSD_FIFO_ADDR)
				tx_push = 1'b1; // R6
			if (s_reg.rw && s_reg.addr == `RCSD_FIFO_ADDR)
			begin
				rx_pop = 1'b1; // R6
				s_next.refill = 1'b1;
			end
			s_next.addr = ra;
		end
		// Read byte and status byte for the link
		if (ev)
		begin
			s_next.ret.rdata = rd_val;
			s_next.ret.status = {s_reg.radio == rad_xoff || s_reg.radio == rad_pwd,
				state_code(s_reg.radio),
				(tx_count > 7'h31) ? 4'(7'h40 - tx_count) : 4'hF}; // R7
		end
		if (s_reg.refill)
			s_next.ret.rdata = rx_head;
		// Radio progression without a strobe
		unique case (s_reg.radio)
			rad_cal:
				if (s_reg.cal_cnt == CAL_LAST)
				begin
					s_next.radio = s_reg.cal_target; // R10
					s_next.cal_cnt = '0;
				end
				else
					s_next.cal_cnt = s_reg.cal_cnt + `RCSD_CAL_CNT_W'(1);
			rad_rx:
				if (i_rx_valid && rx_count == `RCSD_FIFO_DEPTH)
					s_next.radio = rad_rxovf;
			rad_tx:
				if (i_tx_take && tx_count == 7'h00)
					s_next.radio = rad_txunf;
			rad_wor:
				s_next.wor_cnt = (s_reg.wor_cnt == 16'h0000) ? evt1 : s_reg.wor_cnt - 16'h0001;
			rad_xoff, rad_pwd:
				if (cs_fall)
					s_next.radio = rad_idle;
			rad_idle, rad_fs_on, rad_rxovf, rad_txunf:
				s_next.radio = s_reg.radio;
		endcase
		// Power down only once chip select has gone high
		if (s_reg.pwd_pend && s_reg.cs_sync[1])
		begin
			s_next.radio = rad_pwd; // R15
			s_next.pwd_pend = 1'b0;
		end
		// Strobes, acting on the complete header byte
		if (strobe)
		begin
			unique case (hdr_addr)
				`RCSD_CMD_SYNTH_ON:
					if (s_reg.radio == rad_idle)
					begin
						s_next.radio = autocal ? rad_cal : rad_fs_on; // R9
						s_next.cal_target = rad_fs_on;
					end
					else if (s_reg.radio == rad_rx && cca)
						s_next.radio = rad_fs_on; // R9
				`RCSD_CMD_XOSC_OFF:
					if (s_reg.radio == rad_idle)
						s_next.radio = rad_xoff; // R19
				`RCSD_CMD_SYNTH_CAL:
					if (s_reg.radio == rad_idle)
					begin
						s_next.radio = rad_cal; // R10
						s_next.cal_target = rad_idle;
					end
				`RCSD_CMD_RX_ENABLE:
					if (s_reg.radio == rad_idle && autocal)
					begin
						s_next.radio = rad_cal; // R11
						s_next.cal_target = rad_rx;
					end
					else if (s_reg.radio inside {rad_idle, rad_fs_on, rad_tx})
						s_next.radio = rad_rx; // R11
				`RCSD_CMD_TX_ENABLE:
					if (s_reg.radio == rad_idle && autocal)
					begin
						s_next.radio = rad_cal; // R12
						s_next.cal_target = rad_tx;
					end
					else if (s_reg.radio inside {rad_idle, rad_fs_on})
						s_next.radio = rad_tx; // R12
					else if (s_reg.radio == rad_rx && (!cca || i_channel_clear))
						s_next.radio = rad_tx; // R12
				`RCSD_CMD_GO_IDLE:
				begin
					s_next.radio = rad_idle; // R13
					s_next.cal_cnt = '0;
				end
				`RCSD_CMD_WAKE_POLL:
					if (!rc_off && s_reg.radio == rad_idle)
					begin
						s_next.radio = rad_wor; // R14
						s_next.wor_cnt = evt1;
					end
				`RCSD_CMD_POWER_DOWN:
					s_next.pwd_pend = 1'b1; // R15
				`RCSD_CMD_RX_FLUSH:
					if (s_reg.radio inside {rad_idle, rad_rxovf})
					begin
						rx_flush = 1'b1; // R16
						s_next.radio = rad_idle;
					end
				`RCSD_CMD_TX_FLUSH:
					if (s_reg.radio inside {rad_idle, rad_txunf})
					begin
						tx_flush = 1'b1; // R17
						s_next.radio = rad_idle;
					end
				`RCSD_CMD_WAKE_RELOAD:
					s_next.wor_cnt = evt1; // R18
				`RCSD_CMD_CHIP_RESET:
				begin
					s_next.cfg = {`RCSD_NUM_CFG{`RCSD_CFG_DEFAULT}}; // R1 R20
					s_next.radio = rad_idle;
					s_next.cal_cnt = '0;
					s_next.wor_cnt = 16'h0000;
					s_next.pwd_pend = 1'b0;
					rx_flush = 1'b1;
					tx_flush = 1'b1;
				end
				`RCSD_CMD_NO_OP:
					s_next.radio = s_reg.radio; // R20
				default:
					s_next.radio = s_reg.radio;
			endcase
		end
		if (s_reg.cs_sync[1])
			s_next.hdr_ok = 1'b0;
		s_next.pd_out = s_next.radio == rad_pwd;
		s_next.xoff_out = s_next.radio == rad_xoff;
	end

	// State register; defaults after reset
	always_ff @(posedge i_clock or posedge i_rst)
		if (i_rst)
		begin
			s_reg <= '0;
			s_reg.cfg <= {`RCSD_NUM_CFG{`RCSD_CFG_DEFAULT}}; // R1
			// Select idles high, so no false frame or output enable after reset
			s_reg.cs_sync <= 3'h7;
		end
		else
			s_reg <= s_next;

	assign o_so_oe = s_reg.oe;
	assign o_tx_octet = s_reg.tx_out;
	assign o_tx_strobe = s_reg.tx_stb;
	assign o_radio_state = 8'(s_reg.radio);
	assign o_power_down = s_reg.pd_out;
	assign o_xosc_off = s_reg.xoff_out;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	a_reset_cfg_defaults: assert property (strobe && hdr_addr == `RCSD_CMD_CHIP_RESET
		|=> s_reg.cfg == {`RCSD_NUM_CFG{`RCSD_CFG_DEFAULT}} && s_reg.radio == rad_idle) // R1
		else $error("chip reset strobe left state");
	a_cfg_write_lands: assert property (data_wr && s_reg.addr <= `RCSD_CFG_LAST && !strobe
		|=> s_reg.cfg[$past(s_reg.addr)] == $past(ev_word.octet)) // R4
		else $error("config write lost");
	a_status_ro: assert property (data_wr && s_reg.addr > `RCSD_CFG_LAST
		|=> $stable(s_reg.cfg)) // R5
		else $error("status write changed config");
	a_fifo_push: assert property (data_wr && s_reg.addr == `RCSD_FIFO_ADDR && !tx_pop
		&& !tx_flush && tx_count != `RCSD_FIFO_DEPTH |=> tx_count == $past(tx_count) + 7'h01) // R6
		else $error("tx fifo write not pushed");
	a_cal_then_idle: assert property (strobe && hdr_addr == `RCSD_CMD_SYNTH_CAL
		&& s_reg.radio == rad_idle |=> s_reg.radio == rad_cal && s_reg.cal_target == rad_idle) // R10
		else $error("calibrate strobe ignored");
	a_rx_autocal: assert property (strobe && hdr_addr == `RCSD_CMD_RX_ENABLE && autocal
		&& s_reg.radio == rad_idle |=> s_reg.radio == rad_cal ##1 s_reg.cal_target == rad_rx) // R11
		else $error("receive strobe skipped calibration");
	a_tx_cca_busy: assert property (strobe && hdr_addr == `RCSD_CMD_TX_ENABLE && cca
		&& !i_channel_clear && s_reg.radio == rad_rx |=> s_reg.radio == rad_rx) // R12
		else $error("transmit on busy channel");
	a_idle_exit: assert property (strobe && hdr_addr == `RCSD_CMD_GO_IDLE && !s_reg.pwd_pend
		|=> s_reg.radio == rad_idle) // R13
		else $error("idle strobe ignored");
	a_wor_gate: assert property (strobe && hdr_addr == `RCSD_CMD_WAKE_POLL && rc_off
		|=> s_reg.radio != rad_wor) // R14
		else $error("polling started with RC oscillator off");
	a_pwd_wait_cs: assert property (s_reg.pwd_pend && !s_reg.cs_sync[1] && !strobe
		&& s_reg.radio != rad_pwd |=> s_reg.radio != rad_pwd) // R15
		else $error("power down before chip select high");
	a_rx_flush: assert property (strobe && hdr_addr == `RCSD_CMD_RX_FLUSH
		&& s_reg.radio == rad_idle |=> rx_count == 7'h00) // R16
		else $error("receive flush left data");
endmodule : rcsd_core

// ==== design/rcsd_defines.svh ====
`ifndef RCSD_DEFINES_SVH
`define RCSD_DEFINES_SVH
// Register space
`define RCSD_NUM_CFG 47
`define RCSD_CFG_LAST 6'h2E
`define RCSD_CFG_DEFAULT 8'h00
`define RCSD_RADIO_SM_CONFIG1_IDX 6'h17
`define RCSD_RADIO_SM_CONFIG0_IDX 6'h18
`define RCSD_WAKE_POLL_CONTROL_IDX 6'h20
`define RCSD_STAT_FIRST 6'h30
`define RCSD_STAT_LAST 6'h3B
`define RCSD_FIFO_ADDR 6'h3F
// Field positions
`define RCSD_AUTOCAL_MSB 5
`define RCSD_AUTOCAL_LSB 4
`define RCSD_AUTOCAL_FROM_IDLE 2'h1
`define RCSD_CCA_MSB 5
`define RCSD_CCA_LSB 4
`define RCSD_RC_OSC_POWERDOWN_BIT 7
`define RCSD_EVT1_MSB 6
`define RCSD_EVT1_LSB 4
// Command strobe addresses
`define RCSD_CMD_CHIP_RESET 6'h30
`define RCSD_CMD_SYNTH_ON 6'h31
`define RCSD_CMD_XOSC_OFF 6'h32
`define RCSD_CMD_SYNTH_CAL 6'h33
`define RCSD_CMD_RX_ENABLE 6'h34
`define RCSD_CMD_TX_ENABLE 6'h35
`define RCSD_CMD_GO_IDLE 6'h36
`define RCSD_CMD_GAP 6'h37
`define RCSD_CMD_WAKE_POLL 6'h38
`define RCSD_CMD_POWER_DOWN 6'h39
`define RCSD_CMD_RX_FLUSH 6'h3A
`define RCSD_CMD_TX_FLUSH 6'h3B
`define RCSD_CMD_WAKE_RELOAD 6'h3C
`define RCSD_CMD_NO_OP 6'h3D
// FIFO and timing
`define RCSD_FIFO_DEPTH 7'h40
`define RCSD_CAL_TIME_US 725
`define RCSD_CLK_MHZ 250
`define RCSD_CAL_CNT_W 18
// Arbitrary identification values
`define RCSD_PART_ID 8'h5A
`define RCSD_VERSION_ID 8'h01
`endif

// ==== design/rcsd_pkg.sv ====
package rcsd_pkg;
	// Radio control states
	typedef enum logic [3:0] {rad_idle, rad_cal, rad_fs_on, rad_rx, rad_tx, rad_wor,
		rad_xoff, rad_pwd, rad_rxovf, rad_txunf} rcsd_radio_e;
	// One completed byte from the serial link
	typedef struct packed {
		logic is_hdr;
		logic [7:0] octet;
	} rcsd_ev_s;
	// Bytes held for the serial link to shift out
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] rdata;
	} rcsd_ret_s;
endpackage : rcsd_pkg

// ==== design/rcsd_fifo.sv ====
`timescale 1ns/100ps
`include "rcsd_defines.svh"
module rcsd_fifo
	import rcsd_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic i_flush,
	input wire logic [7:0] i_data,
	output logic [7:0] o_head,
	output logic [6:0] o_count
);
	// Storage, pointers and fill level
	typedef struct packed {
		logic [`RCSD_FIFO_DEPTH-1:0][7:0] mem;
		logic [5:0] wr;
		logic [5:0] rd;
		logic [6:0] cnt;
	} rcsd_fifo_s;
	rcsd_fifo_s s_reg;
	rcsd_fifo_s s_next;
	logic do_push;
	logic do_pop;
	// Next state: full refuses pushes, empty refuses pops
	always_comb
	begin
		s_next = s_reg;
		do_push = i_push && (s_reg.cnt != `RCSD_FIFO_DEPTH);
		do_pop = i_pop && (s_reg.cnt != 7'h00);
		if (do_push)
		begin
			s_next.mem[s_reg.wr] = i_data;
			s_next.wr = s_reg.wr + 6'h01;
		end
		if (do_pop)
			s_next.rd = s_reg.rd + 6'h01;
		if (do_push && !do_pop)
			s_next.cnt = s_reg.cnt + 7'h01;
		else if (do_pop && !do_push)
			s_next.cnt = s_reg.cnt - 7'h01;
		// Flush empties the buffer outright
		if (i_flush)
		begin
			s_next.wr = 6'h00;
			s_next.rd = 6'h00;
			s_next.cnt = 7'h00;
		end
	end
	// State register
	always_ff @(posedge i_clock or posedge i_rst)
		if (i_rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	assign o_head = s_reg.mem[s_reg.rd];
	assign o_count = s_reg.cnt;
endmodule : rcsd_fifo

// ==== design/rcsd_spi_link.sv ====
`timescale 1ns/100ps
`include "rcsd_defines.svh"
module rcsd_spi_link
	import rcsd_pkg::*;
(
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_chip_select_n,
	input wire logic i_mosi,
	input wire rcsd_ret_s i_ret,
	output rcsd_ev_s o_ev,
	output logic o_req_tog,
	output logic o_so
);
	// Framing state, cleared whenever the chip select is high
	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
		logic hdr_done;
		logic rw;
	} rcsd_frame_s;
	// Event word and its toggle, kept across frames
	typedef struct packed {
		rcsd_ev_s ev;
		logic tog;
	} rcsd_evq_s;
	// Output shifter on the falling edge
	typedef struct packed {
		logic [7:0] obyte;
		logic so;
	} rcsd_out_s;
	rcsd_frame_s f_reg;
	rcsd_frame_s f_next;
	rcsd_evq_s e_reg;
	rcsd_evq_s e_next;
	rcsd_out_s o_reg;
	rcsd_out_s o_next;
	logic frame_rst;
	assign frame_rst = i_rst | i_chip_select_n;
	// Shift in MSB first; each full byte toggles a request to the core
	always_comb
	begin
		f_next = f_reg;
		e_next = e_reg;
		f_next.cnt = f_reg.cnt + 3'h1;
		f_next.sh = {f_reg.sh[5:0], i_mosi};
		if (f_reg.cnt == 3'h7)
		begin
			e_next.ev = '{is_hdr: !f_reg.hdr_done, octet: {f_reg.sh, i_mosi}};
			e_next.tog = !e_reg.tog;
			f_next.hdr_done = 1'b1;
			if (!f_reg.hdr_done)
				f_next.rw = f_reg.sh[6];
		end
	end
	// Status during the header and during writes, read data otherwise
	always_comb
	begin
		o_next = o_reg;
		if (!f_reg.hdr_done)
			o_next.so = i_ret.status[~f_reg.cnt]; // R7
		else if (f_reg.cnt == 3'h0)
		begin
			o_next.obyte = f_reg.rw ? i_ret.rdata : i_ret.status; // R7
			o_next.so = o_next.obyte[7];
		end
		else
			o_next.so = o_reg.obyte[~f_reg.cnt];
	end
	// Input side registers
	always_ff @(posedge i_sclk or posedge frame_rst)
		if (frame_rst)
			f_reg <= '0;
		else
			f_reg <= f_next;
	always_ff @(posedge i_sclk or posedge i_rst)
		if (i_rst)
			e_reg <= '0;
		else
			e_reg <= e_next;
	// Output bit changes on the falling edge; zero (ready) before the first edge
	always_ff @(negedge i_sclk or posedge frame_rst)
		if (frame_rst)
			o_reg <= '0;
		else
			o_reg <= o_next;
	assign o_ev = e_reg.ev;
	assign o_req_tog = e_reg.tog;
	assign o_so = o_reg.so;
endmodule : rcsd_spi_link

// ==== testbench/rcsd_host_model.sv ====
`timescale 1ns/100ps
module rcsd_host_model
	import rcsd_pkg::*;
(
	output logic o_sclk,
	output logic o_chip_select_n,
	output logic o_mosi,
	input wire logic i_so
);
	// Half of the 125 ns link clock period
	localparam realtime HALF = 62.5;
	// Serial clock stands low and select stays high between frames
	initial
	begin
		o_sclk = 1'b0;
		o_chip_select_n = 1'b1;
		o_mosi = 1'b1;
	end
	// One framed transfer of n bytes, MSB first, mode 0
	task automatic frame(input logic [7:0] tb [4], input int n, output logic [7:0] rb [4]);
		o_chip_select_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			for (int k = 7; k >= 0; k--)
			begin
				o_mosi = tb[i][k];
				#HALF o_sclk = 1'b1;
				rb[i][k] = i_so;
				#HALF o_sclk = 1'b0;
			end
		end
		#HALF o_chip_select_n = 1'b1;
		// Released data line does not keep its last bit
		o_mosi = ~o_mosi;
		#HALF;
	endtask : frame
endmodule : rcsd_host_model

// ==== testbench/radio_command_strobe_decoder_tb.sv ====
`timescale 1ns/100ps
module radio_command_strobe_decoder_tb
	import rcsd_pkg::*;
;
	logic i_clock, i_rst, sclk, chip_select_n, mosi, i_channel_clear, i_rx_valid, i_tx_take;
	logic [7:0] i_rx_octet, tx_octet, radio_state, hdr_st, last_rd, a, v, w;
	logic so, so_oe, oe_on, tx_strobe, power_down, xosc_off, saw_cal, pd_early;
	int n_fail, n_checks;
	// Expected register and FIFO contents
	int cfg [47];
	logic [7:0] rxq [$];
	logic [7:0] txq [$];
	// Strobe walk and the state each one reaches
	logic [5:0] seq_c [8] = '{6'h34, 6'h36, 6'h35, 6'h36, 6'h31, 6'h36, 6'h38, 6'h36};
	logic [7:0] seq_s [8] = '{8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h05, 8'h00};
	rcsd_core #(.CAL_CYCLES(20)) u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_sclk(sclk),
		.i_chip_select_n(chip_select_n), .i_mosi(mosi), .i_channel_clear(i_channel_clear),
		.i_rx_valid(i_rx_valid), .i_rx_octet(i_rx_octet), .i_tx_take(i_tx_take), .o_so(so),
		.o_so_oe(so_oe), .o_tx_octet(tx_octet), .o_tx_strobe(tx_strobe),
		.o_radio_state(radio_state), .o_power_down(power_down), .o_xosc_off(xosc_off));
	rcsd_host_model u_host (.o_sclk(sclk), .o_chip_select_n(chip_select_n), .o_mosi(mosi),
		.i_so(so));
	// Core clock, 4 ns period
	always #2 i_clock = ~i_clock;
	// Note calibration passes and power-down during an open frame
	always @(posedge i_clock)
	begin
		if (radio_state === 8'h01)
			saw_cal = 1'b1;
		if (chip_select_n === 1'b0 && power_down === 1'b1)
			pd_early = 1'b1;
		// Serial output is driven at some point inside a frame
		if (chip_select_n === 1'b0 && so_oe === 1'b1)
			oe_on = 1'b1;
	end
	// Status byte state field for a state code
	function automatic logic [7:0] st3(input logic [7:0] s);
		case (s)
			8'h03: return 8'h01;
			8'h04: return 8'h02;
			8'h02: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction : st3
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask : chk
	// One host access of n bytes, then a short settle
	task automatic acc(input logic [7:0] h, input logic [7:0] d0, input logic [7:0] d1,
		input int n);
		logic [7:0] t [4];
		logic [7:0] r [4];
		t = '{h, d0, d1, 8'h00};
		u_host.frame(t, n, r);
		hdr_st = r[0];
		last_rd = r[n - 1];
		repeat (6) @(negedge i_clock);
	endtask : acc
	// Header-only strobe
	task automatic cmd(input logic [5:0] c);
		acc({2'b00, c}, 8'h00, 8'h00, 1);
	endtask : cmd
	// Single read, header carries the read bit
	task automatic rd(input logic [7:0] h);
		acc(h, 8'h00, 8'h00, 2);
	endtask : rd
	// Counts and verdict
	task automatic summarize();
		$display("checks=%0d failures=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// Hang guard
	initial
	begin
		#300000;
		n_fail++;
		summarize();
	end
	// Main sequence
	initial
	begin
		i_clock = 1'b0;
		i_rst = 1'b1;
		i_channel_clear = 1'b1;
		i_rx_valid = 1'b0;
		i_rx_octet = 8'h00;
		i_tx_take = 1'b0;
		saw_cal = 1'b0;
		pd_early = 1'b0;
		oe_on = 1'b0;
		void'($urandom(32'hA067));
		repeat (5) @(negedge i_clock);
		i_rst = 1'b0;
		repeat (3) @(negedge i_clock);
		// Plain registers: default, then written value
		for (int i = 0; i < 4; i++)
		begin
			a = 8'($urandom % 23);
			v = 8'($urandom);
			rd(8'h80 | a);
			chk(last_rd, 8'(cfg[a]));
			acc(a, v, 8'h00, 2);
			cfg[a] = v;
			rd(8'h80 | a);
			chk(last_rd, 8'(cfg[a]));
		end
		// Burst write steps the address
		v = 8'($urandom);
		w = 8'($urandom);
		acc(8'h45, v, w, 3);
		rd(8'h86);
		chk(last_rd, w);
		rd(8'hF5);
		chk(last_rd, 8'h00);
		// Strobe walk with status byte follow-up
		for (int i = 0; i < 8; i++)
		begin
			cmd(seq_c[i]);
			chk(radio_state, seq_s[i]);
			cmd(6'h3D);
			cmd(6'h3D);
			chk({4'h0, hdr_st[7:4]}, st3(seq_s[i]));
		end
		saw_cal = 1'b0;
		cmd(6'h33);
		chk({7'h00, saw_cal}, 8'h01);
		chk(radio_state, 8'h00);
		// Timer reload takes the Event1 field
		acc(8'h20, 8'h50, 8'h00, 2);
		cmd(6'h3C);
		rd(8'hF7);
		chk(last_rd, 8'h05);
		acc(8'h20, 8'hD0, 8'h00, 2);
		cmd(6'h38);
		chk(radio_state, 8'h00);
		cmd(6'h32);
		chk({7'h00, xosc_off}, 8'h01);
		cmd(6'h30);
		cfg = '{default: 0};
		chk({7'h00, xosc_off}, 8'h00);
		rd(8'hA0);
		chk(last_rd, 8'h00);
		// Autocalibration from idle before receive
		acc(8'h18, 8'h10, 8'h00, 2);
		saw_cal = 1'b0;
		cmd(6'h34);
		chk({7'h00, saw_cal}, 8'h01);
		chk(radio_state, 8'h03);
		// Valid stands for two cycles, one byte taken at each rising edge
		i_rx_valid = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			i_rx_octet = 8'($urandom);
			rxq.push_back(i_rx_octet);
			@(negedge i_clock);
		end
		i_rx_valid = 1'b0;
		rd(8'hFB);
		chk(last_rd, 8'h02);
		cmd(6'h3A);
		rd(8'hBF);
		chk(last_rd, rxq.pop_front());
		// Clear channel gates receive to transmit
		acc(8'h17, 8'h10, 8'h00, 2);
		i_channel_clear = 1'b0;
		cmd(6'h35);
		chk(radio_state, 8'h03);
		cmd(6'h31);
		chk(radio_state, 8'h02);
		cmd(6'h34);
		i_channel_clear = 1'b1;
		cmd(6'h35);
		chk(radio_state, 8'h04);
		cmd(6'h36);
		cmd(6'h3A);
		rd(8'hFB);
		chk(last_rd, 8'h00);
		// Transmit FIFO fill, take, refused and legal flush
		for (int i = 0; i < 3; i++)
			txq.push_back(8'($urandom));
		acc(8'h7F, txq[0], txq[1], 3);
		acc(8'h3F, txq[2], 8'h00, 2);
		rd(8'hFA);
		chk(last_rd, 8'h03);
		cmd(6'h35);
		i_tx_take = 1'b1;
		@(negedge i_clock);
		i_tx_take = 1'b0;
		for (int i = 0; i < 3 && tx_strobe !== 1'b1; i++)
			@(negedge i_clock);
		chk({7'h00, tx_strobe}, 8'h01);
		chk(tx_octet, txq.pop_front());
		cmd(6'h3B);
		cmd(6'h36);
		rd(8'hFA);
		chk(last_rd, 8'h02);
		cmd(6'h3B);
		rd(8'hFA);
		chk(last_rd, 8'h00);
		// Power-down waits for the end of the frame
		pd_early = 1'b0;
		cmd(6'h39);
		chk({7'h00, pd_early}, 8'h00);
		chk({7'h00, power_down}, 8'h01);
		cmd(6'h3D);
		cmd(6'h3D);
		chk(radio_state, 8'h00);
		chk({7'h00, oe_on}, 8'h01);
		chk({7'h00, so_oe}, 8'h00);
		summarize();
	end
endmodule : radio_command_strobe_decoder_tb
